// ==== fcb_defines.vh ====
// register map, field positions, reset values and timing for the field boost block
`ifndef FCB_DEFINES_VH
`define FCB_DEFINES_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define FCB_OFS_CTRL       12'h000
`define FCB_OFS_MIN_LIMIT  12'h004
`define FCB_OFS_BOOST_LVL  12'h008
`define FCB_OFS_BOOST_TIME 12'h00C
`define FCB_OFS_MAINS_NOM  12'h010
`define FCB_OFS_STATUS     12'h014
`define FCB_OFS_FIELD_REF  12'h018

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define FCB_CTRL_DYN_FW    0
`define FCB_ST_ALARM       0
`define FCB_ST_BOOST       1
`define FCB_ST_CANCEL      2
`define FCB_ST_RUN         3

// -----------------------------------------------------------------
// ranges and reset values (percent, tenths of a second, volts)
// -----------------------------------------------------------------
`define FCB_MIN_LIM_LO     8'h0A
`define FCB_MIN_LIM_HI     8'h64
`define FCB_MIN_LIM_RST    8'h19
`define FCB_BOOST_LO       8'h64
`define FCB_BOOST_HI       8'h78
`define FCB_BOOST_RST      8'h64
`define FCB_BTIME_HI       10'h258
`define FCB_BTIME_RST      10'h064
`define FCB_MAINS_LO       16'h000A
`define FCB_MAINS_HI       16'h02B2
`define FCB_MAINS_RST      16'h0190
`define FCB_NOMINAL_PCT    8'h64

// -----------------------------------------------------------------
// overvoltage threshold: armature > mains * 1316 / (1000 * divisor)
// -----------------------------------------------------------------
`define FCB_OV_MUL         32'd1316
`define FCB_OV_SCALE       32'd1000
`define FCB_OV_DIV         32'd2

// -----------------------------------------------------------------
// timing: boost time counts 100 ms ticks at 100 MHz
// -----------------------------------------------------------------
`define FCB_TICK_MS        32'd100
`define FCB_CLK_KHZ        32'd100000
`define FCB_TICK_CYCLES    (`FCB_TICK_MS * `FCB_CLK_KHZ)

// -----------------------------------------------------------------
// bus responses
// -----------------------------------------------------------------
`define FCB_RESP_OKAY      2'h0
`define FCB_RESP_SLVERR    2'h2

`endif

// ==== fcb_top.v ====
// field current floor, underlimit alarm and timed field boost with an AXI4-Lite slave
`timescale 1ns/1ps
`include "fcb_defines.vh"

module fcb_top #(
	parameter [31:0] TICK_CYCLES = `FCB_TICK_CYCLES,
	parameter [31:0] OV_DIV      = `FCB_OV_DIV
) (
	input  wire        I_CLOCK,         // 100 MHz clock
	input  wire        I_RST_N,         // async reset, active low
	input  wire        I_RUN,           // run command pin
	input  wire        I_BOOST_PERMIT,  // permit digital input, closed = 1
	input  wire [15:0] I_ARM_VOLT,      // armature volts, same clock
	input  wire [7:0]  I_FW_DEMAND_PCT, // weakening demand, same clock
	output wire [7:0]  O_FIELD_REF_PCT, // field current reference
	output wire        O_ALARM,         // field underlimit alarm
	output wire        O_LOCK,          // equipment lock
	output wire        O_BOOST_ACTIVE,  // boost in force
	input  wire [11:0] S_AXI_AWADDR,    // write address
	input  wire        S_AXI_AWVALID,   // write address valid
	output wire        S_AXI_AWREADY,   // write address ready
	input  wire [31:0] S_AXI_WDATA,     // write data
	input  wire [3:0]  S_AXI_WSTRB,     // write strobes
	input  wire        S_AXI_WVALID,    // write data valid
	output wire        S_AXI_WREADY,    // write data ready
	output wire [1:0]  S_AXI_BRESP,     // write response
	output wire        S_AXI_BVALID,    // write response valid
	input  wire        S_AXI_BREADY,    // write response ready
	input  wire [11:0] S_AXI_ARADDR,    // read address
	input  wire        S_AXI_ARVALID,   // read address valid
	output wire        S_AXI_ARREADY,   // read address ready
	output wire [31:0] S_AXI_RDATA,     // read data
	output wire [1:0]  S_AXI_RRESP,     // read response
	output wire        S_AXI_RVALID,    // read data valid
	input  wire        S_AXI_RREADY     // read data ready
);

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	reg  [1:0]  run_sync;
	reg  [1:0]  permit_sync;
	reg         run_prev;

	// two stages; only the second stage is read
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			run_sync    <= 2'h0;
			permit_sync <= 2'h0;
			run_prev    <= 1'b0;
		end else begin
			run_sync    <= {run_sync[0], I_RUN};
			permit_sync <= {permit_sync[0], I_BOOST_PERMIT};
			run_prev    <= run_sync[1];
		end
	end

	wire run      = run_sync[1];
	wire permit   = permit_sync[1];
	wire run_rise = run & ~run_prev;

	// -----------------------------------------------------------------
	// settings, state and bus slave state
	// -----------------------------------------------------------------
	reg         dyn_fw;
	reg  [7:0]  field_min_limit_pct;
	reg  [7:0]  field_boost_level_pct;
	reg  [9:0]  field_boost_duration;
	reg  [15:0] mains_nominal_param;
	reg         field_underlimit_alarm;
	reg         lock;
	reg         cancelled;
	reg         boost_active;
	reg  [9:0]  boost_left;
	reg  [31:0] tick_cnt;
	reg  [7:0]  field_ref;
	reg         awready;
	reg         wready;
	reg         aw_held;
	reg         w_held;
	reg  [11:0] aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         bvalid;
	reg  [1:0]  bresp;
	reg         arready;
	reg         rvalid;
	reg  [31:0] rdata;
	reg  [1:0]  rresp;

	// byte lanes; unstrobed lanes are written as zero, never kept
	wire [31:0] wr_word;
	genvar      lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign wr_word[lane*8 +: 8] = w_strb[lane] ? w_data[lane*8 +: 8] : 8'h00;
		end
	endgenerate

	wire        do_write = aw_held & w_held & ~bvalid;

	// write values clamped into their legal ranges
	reg  [7:0]  next_min;
	reg  [7:0]  next_boost;
	reg  [9:0]  next_btime;
	reg  [15:0] next_mains;
	always @* begin
		next_min = (wr_word[7:0] < `FCB_MIN_LIM_LO) ? `FCB_MIN_LIM_LO :
			(wr_word[7:0] > `FCB_MIN_LIM_HI) ? `FCB_MIN_LIM_HI : wr_word[7:0];
		next_boost = (wr_word[7:0] < `FCB_BOOST_LO) ? `FCB_BOOST_LO :
			(wr_word[7:0] > `FCB_BOOST_HI) ? `FCB_BOOST_HI : wr_word[7:0];
		next_btime = (wr_word[9:0] > `FCB_BTIME_HI) ? `FCB_BTIME_HI : wr_word[9:0];
		next_mains = (wr_word[15:0] < `FCB_MAINS_LO) ? `FCB_MAINS_LO :
			(wr_word[15:0] > `FCB_MAINS_HI) ? `FCB_MAINS_HI : wr_word[15:0];
	end

	// -----------------------------------------------------------------
	// derived conditions
	// -----------------------------------------------------------------
	// cross-multiplied so no divider is needed; 32 bits cover the worst case
	wire [31:0] arm_scaled   = {16'h0, I_ARM_VOLT} * `FCB_OV_SCALE * OV_DIV;
	wire [31:0] mains_scaled = {16'h0, mains_nominal_param} * `FCB_OV_MUL;
	wire        over_volt    = arm_scaled > mains_scaled;
	wire        under_floor  = dyn_fw & (I_FW_DEMAND_PCT < field_min_limit_pct);
	wire        tick         = (tick_cnt == TICK_CYCLES - 32'h1);

	// -----------------------------------------------------------------
	// boost timer and cancellation
	// -----------------------------------------------------------------
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			boost_left   <= 10'h0;
			tick_cnt     <= 32'h0;
			cancelled    <= 1'b0;
			boost_active <= 1'b0;
		end else begin
			if (run_rise) begin
				// timing starts at the run command
				boost_left <= field_boost_duration;
				tick_cnt   <= 32'h0;
				// re-arm only on a new run
				cancelled  <= 1'b0;
			end else if (!run) begin
				boost_left <= 10'h0;
				tick_cnt   <= 32'h0;
			end else if (boost_left != 10'h0) begin
				tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
				if (tick) begin
					boost_left <= boost_left - 10'h1;
				end
			end
			if (run && over_volt) begin
				cancelled <= 1'b1;
			end
			boost_active <= run & ~run_rise & (boost_left != 10'h0) & permit
				& ~cancelled & ~over_volt;
		end
	end

	// -----------------------------------------------------------------
	// field reference selection
	// -----------------------------------------------------------------
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			field_ref <= `FCB_NOMINAL_PCT;
		end else if (boost_active) begin
			// boost level is the forcing target
			field_ref <= field_boost_level_pct;
		end else if (dyn_fw) begin
			field_ref <= under_floor ? field_min_limit_pct : I_FW_DEMAND_PCT;
		end else begin
			field_ref <= `FCB_NOMINAL_PCT;
		end
	end

	// -----------------------------------------------------------------
	// register writes, alarm and lock
	// -----------------------------------------------------------------
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			dyn_fw                 <= 1'b0;
			field_min_limit_pct    <= `FCB_MIN_LIM_RST;
			field_boost_level_pct  <= `FCB_BOOST_RST;
			field_boost_duration   <= `FCB_BTIME_RST;
			mains_nominal_param    <= `FCB_MAINS_RST;
			field_underlimit_alarm <= 1'b0;
			lock                   <= 1'b0;
		end else begin
			if (do_write) begin
				case (aw_addr)
					`FCB_OFS_CTRL: begin
						dyn_fw <= wr_word[`FCB_CTRL_DYN_FW];
					end
					`FCB_OFS_MIN_LIMIT: begin
						field_min_limit_pct <= next_min;
					end
					`FCB_OFS_BOOST_LVL: begin
						field_boost_level_pct <= next_boost;
					end
					`FCB_OFS_BOOST_TIME: begin
						field_boost_duration <= next_btime;
					end
					`FCB_OFS_MAINS_NOM: begin
						mains_nominal_param <= next_mains;
					end
					`FCB_OFS_STATUS: begin
						// write one clears; a same-cycle trip wins below
						if (wr_word[`FCB_ST_ALARM]) begin
							field_underlimit_alarm <= 1'b0;
							lock                   <= 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
			if (under_floor) begin
				field_underlimit_alarm <= 1'b1;
				lock                   <= 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// AXI4-Lite write channel
	// -----------------------------------------------------------------
	wire wr_mapped = (aw_addr <= `FCB_OFS_STATUS) && (aw_addr[1:0] == 2'h0);

	// address and data taken in either order, answered once both are held
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 12'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= `FCB_RESP_OKAY;
		end else begin
			if (awready && S_AXI_AWVALID) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
				awready <= 1'b0;
			end
			if (wready && S_AXI_WVALID) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_mapped ? `FCB_RESP_OKAY : `FCB_RESP_SLVERR;
			end
			if (bvalid && S_AXI_BREADY) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// AXI4-Lite read channel
	// -----------------------------------------------------------------
	always @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= `FCB_RESP_OKAY;
		end else if (arready && S_AXI_ARVALID) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `FCB_RESP_OKAY;
			case (S_AXI_ARADDR)
				`FCB_OFS_CTRL:       rdata <= {31'h0, dyn_fw};
				`FCB_OFS_MIN_LIMIT:  rdata <= {24'h0, field_min_limit_pct};
				`FCB_OFS_BOOST_LVL:  rdata <= {24'h0, field_boost_level_pct};
				`FCB_OFS_BOOST_TIME: rdata <= {22'h0, field_boost_duration};
				`FCB_OFS_MAINS_NOM:  rdata <= {16'h0, mains_nominal_param};
				`FCB_OFS_STATUS:     rdata <= {28'h0, run, cancelled,
					boost_active, field_underlimit_alarm};
				`FCB_OFS_FIELD_REF:  rdata <= {24'h0, field_ref};
				default: begin
					rdata <= 32'h0;
					rresp <= `FCB_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && S_AXI_RREADY) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// outputs, all from flops
	// -----------------------------------------------------------------
	assign O_FIELD_REF_PCT = field_ref;
	assign O_ALARM         = field_underlimit_alarm;
	assign O_LOCK          = lock;
	assign O_BOOST_ACTIVE  = boost_active;
	assign S_AXI_AWREADY   = awready;
	assign S_AXI_WREADY    = wready;
	assign S_AXI_BRESP     = bresp;
	assign S_AXI_BVALID    = bvalid;
	assign S_AXI_ARREADY   = arready;
	assign S_AXI_RDATA     = rdata;
	assign S_AXI_RRESP     = rresp;
	assign S_AXI_RVALID    = rvalid;

endmodule

// ==== fcb_monitor.sv ====
// assertion checker on the field boost block pins and bus handshakes
`timescale 1ns/1ps
module fcb_monitor #(
	parameter [31:0] TICK_CYCLES = 32'd4, // boost tick
	parameter [31:0] OV_DIV      = 32'd2  // ov divisor
) (
	input wire        I_CLOCK,         // clock
	input wire        I_RST_N,         // reset
	input wire        I_RUN,           // run
	input wire        I_BOOST_PERMIT,  // permit
	input wire [15:0] I_ARM_VOLT,      // armature
	input wire [7:0]  I_FW_DEMAND_PCT, // demand
	input wire [7:0]  O_FIELD_REF_PCT, // reference
	input wire        O_ALARM,         // alarm
	input wire        O_LOCK,          // lock
	input wire        O_BOOST_ACTIVE,  // boost
	input wire        S_AXI_AWVALID,   // aw valid
	input wire        S_AXI_AWREADY,   // aw ready
	input wire        S_AXI_WVALID,    // w valid
	input wire        S_AXI_WREADY,    // w ready
	input wire        S_AXI_BVALID,    // b valid
	input wire        S_AXI_ARVALID,   // ar valid
	input wire        S_AXI_ARREADY,   // ar ready
	input wire        S_AXI_RVALID,    // r valid
	input wire        S_AXI_RREADY     // r ready
);
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// over the limit for any legal mains, as mains is not visible here
	wire ov_any = ({16'h0000, I_ARM_VOLT} * 32'd1000 * OV_DIV) > 32'd908040;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	sequence s_boost_on;
		$rose(O_BOOST_ACTIVE);
	endsequence
	sequence s_boost_off;
		$fell(O_BOOST_ACTIVE) ##0 (I_FW_DEMAND_PCT <= 8'h64);
	endsequence
	// -----------------------------------------------------------------
	// properties
	// -----------------------------------------------------------------
	a_floor_bound: assert property (O_FIELD_REF_PCT >= 8'h0A)
		else $error("field reference under floor range");
	a_boost_ceiling: assert property (O_FIELD_REF_PCT <= 8'h78)
		else $error("field reference over boost range");
	a_lock_alarm: assert property (O_LOCK == O_ALARM)
		else $error("lock differs from alarm");
	a_alarm_sticky: assert property (O_ALARM && S_AXI_WREADY |=> O_ALARM)
		else $error("alarm dropped without clear");
	a_boost_from_run: assert property (s_boost_on |-> $past(I_RUN, 3))
		else $error("boost without run");
	a_permit_gate: assert property (!I_BOOST_PERMIT [*4] |-> !O_BOOST_ACTIVE)
		else $error("boost with permit open");
	a_ov_cancel: assert property (ov_any && I_RUN && O_BOOST_ACTIVE
		|-> ##[1:2] !O_BOOST_ACTIVE)
		else $error("boost kept in overvoltage");
	a_ref_restore: assert property (s_boost_off |-> ##1 O_FIELD_REF_PCT <= 8'h64)
		else $error("reference not restored");
	a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
		else $error("write not answered");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
		else $error("read data withdrawn");
endmodule
bind fcb_top fcb_monitor #(.TICK_CYCLES(TICK_CYCLES), .OV_DIV(OV_DIV)) u_mon (.*);

// ==== fcb_field_model.sv ====
// behavioural field winding and armature as seen by the boost block
`timescale 1ns/1ps
module fcb_field_model (
	input  wire [7:0]  i_ref_pct,   // field reference percent
	input  wire        i_overvolt,  // force armature overvoltage
	input  wire [7:0]  i_demand,    // weakening demand request
	output wire [15:0] o_arm_volt,  // armature volts
	output wire [7:0]  o_fw_demand, // weakening demand
	output wire        o_overdrive  // field asked above supply max
);
	// 500 V beats any forcing cutoff, 200 V only those for mains up to 303 V
	assign o_arm_volt = i_overvolt ? 16'h01F4 : 16'h00C8;
	assign o_fw_demand = i_demand;
	// supply maximum
	// boost ceiling set to the supply max, so above 120 would overdrive
	assign o_overdrive = i_ref_pct > 8'h78;
endmodule

// ==== tb.sv ====
// self-checking testbench for the field boost block
`timescale 1ns/1ps
module tb;
	typedef struct {logic [11:0] a; logic we; logic [31:0] w, e; logic [1:0] br, rr;} fcb_row_t;
	logic        clk, rst_n, run, permit, ov, awv, wv, arv, rready;
	logic [7:0]  dem;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  strb;
	wire  [31:0] rdata;
	wire  [15:0] arm;
	wire  [7:0]  ref_pct, fdem;
	wire         alarm, lock, boost, awrdy, wrdy, bvalid, arrdy, rvalid, odrv;
	wire  [1:0]  bresp, rresp;
	int          err_count, cmp_count, cyc;
	fcb_row_t rows [16] = '{
		'{12'h004, 0, 32'h00, 32'h19, 0, 0}, '{12'h008, 0, 32'h00, 32'h64, 0, 0},
		'{12'h00C, 0, 32'h00, 32'h64, 0, 0}, '{12'h010, 0, 32'h00, 32'h190, 0, 0},
		'{12'h000, 0, 32'h00, 32'h00, 0, 0}, '{12'h014, 0, 32'h00, 32'h00, 0, 0},
		'{12'h018, 0, 32'h00, 32'h64, 0, 0}, '{12'h004, 1, 32'h05, 32'h0A, 0, 0},
		'{12'h004, 1, 32'hC8, 32'h64, 0, 0}, '{12'h008, 1, 32'h82, 32'h78, 0, 0},
		'{12'h008, 1, 32'h63, 32'h64, 0, 0}, '{12'h00C, 1, 32'h2BC, 32'h258, 0, 0},
		'{12'h010, 1, 32'h05, 32'h0A, 0, 0}, '{12'h010, 1, 32'h190, 32'h190, 0, 0},
		'{12'h018, 1, 32'h37, 32'h64, 2, 0}, '{12'h01C, 1, 32'h01, 32'h00, 2, 2}};
	fcb_top #(.TICK_CYCLES(32'd4)) u_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_RUN(run),
		.I_BOOST_PERMIT(permit), .I_ARM_VOLT(arm), .I_FW_DEMAND_PCT(fdem),
		.O_FIELD_REF_PCT(ref_pct), .O_ALARM(alarm), .O_LOCK(lock), .O_BOOST_ACTIVE(boost),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));
	fcb_field_model u_fld (.i_ref_pct(ref_pct), .i_overvolt(ov),
		.i_demand(dem), .o_arm_volt(arm), .o_fw_demand(fdem), .o_overdrive(odrv));
	// -----------------------------------------------------------------
	// clock, watchdog and shared tasks
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// whole run needs about 230 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// wide enough for a response code beside a full data word
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// aw and w offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ta, tw;
		ta = 0;
		tw = 0;
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (awrdy && !ta) begin
				ta = 1;
				awv <= 1'b0;
			end
			if (wrdy && !tw) begin
				tw = 1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		r = bresp;
	endtask
	// rready comes late on purpose so read data must stand
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arv <= 1'b1;
		do @(posedge clk); while (!arrdy);
		arv <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic pulse_run(input int n);
		run <= 1'b0;
		repeat (4) @(posedge clk);
		run <= 1'b1;
		repeat (n) @(posedge clk);
	endtask
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		{rst_n, run, permit, ov, awv, wv, arv, rready} = 8'h00;
		{awaddr, araddr, wdata, dem} = {12'h000, 12'h000, 32'h0, 8'h64};
		strb = 4'hF;
		repeat (5) @(posedge clk);
		chk({boost, alarm, lock, ref_pct, awrdy, arrdy, bvalid, rvalid}, 32'h64C);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].we) begin
				wr(rows[i].a, rows[i].w, r);
				chk(r, rows[i].br);
			end
			rd(rows[i].a, d, r);
			chk({r, d}, {rows[i].rr, rows[i].e});
		end
		// lane 1 alone lands, so 500 volts reads back as 256
		strb <= 4'h2;
		wr(12'h010, 32'h1F4, r);
		strb <= 4'hF;
		rd(12'h010, d, r);
		chk({r, d}, 34'h100);
		wr(12'h010, 32'h190, r);
		// floor and alarm only with dynamic weakening
		dem <= 8'h05;
		repeat (4) @(posedge clk);
		chk({alarm, ref_pct}, 9'h064);
		wr(12'h004, 32'h1E, r);
		wr(12'h000, 32'h01, r);
		repeat (3) @(posedge clk);
		chk({alarm, lock, ref_pct}, 10'h31E);
		dem <= 8'h50;
		wr(12'h014, 32'h01, r);
		repeat (2) @(posedge clk);
		chk({alarm, lock}, 2'b00);
		wr(12'h000, 32'h00, r);
		wr(12'h008, 32'h73, r);
		wr(12'h00C, 32'h03, r);
		permit <= 1'b1;
		n = 0;
		pulse_run(0);
		repeat (30) begin
			@(posedge clk);
			if (boost) n++;
			if (boost && n == 5) chk({odrv, ref_pct}, 9'h073);
		end
		// three ticks of four cycles each
		chk(n, 12);
		chk(ref_pct, 8'h64);
		permit <= 1'b0;
		pulse_run(10);
		chk(boost, 1'b0);
		permit <= 1'b1;
		wr(12'h00C, 32'h258, r);
		pulse_run(8);
		chk(boost, 1'b1);
		ov <= 1'b1;
		repeat (3) @(posedge clk);
		ov <= 1'b0;
		repeat (6) @(posedge clk);
		rd(12'h014, d, r);
		chk({boost, d[2], ref_pct}, 10'h164);
		pulse_run(8);
		chk(boost, 1'b1);
		wr(12'h00C, 32'h00, r);
		pulse_run(10);
		chk(boost, 1'b0);
		// mid-run reset: outputs and settings back to reset values
		wr(12'h004, 32'h50, r);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({boost, alarm, lock, ref_pct, awrdy, arrdy, bvalid, rvalid}, 32'h64C);
		rst_n <= 1'b1;
		rd(12'h004, d, r);
		chk({r, d}, 34'h19);
		wrap_up();
	end
endmodule
